// [src/serial_channel_mode_registers.sv]
// per-channel write-only mode registers with apb access
//
// Behaviour
// - eight-bit vector register, unset at reset
// - receive parameters fields; enable cleared by reset
// - clock, sync, stop and parity mode fields
// - transmit parameters; reset clears modem, break fields
// - sync or station address meaning per mode
// - pointer selects register; point high extends
//
// Register access over APB and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module serial_channel_mode_registers
   import mode_regs_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        nrst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [7:0]  frameAddr,
   input  wire logic        frameValid,
   input  wire logic        rangeMode,
   output logic             frameAccept,
   output logic      [7:0]  vectorOut,
   output logic             rxEnable,
   output logic             syncLoadInhibit,
   output logic             addressSearch,
   output logic             rxCrcEnable,
   output logic             syncSearchState,
   output logic             autoEnable,
   output logic      [1:0]  rxCharLen,
   output logic      [1:0]  clockDivide,
   output logic      [1:0]  syncMode,
   output logic      [1:0]  stopMode,
   output logic             parityEven,
   output logic             parityEnable,
   output logic             dtr,
   output logic      [1:0]  txCharLen,
   output logic             sendBreak,
   output logic             txEnable,
   output logic             crc16Select,
   output logic             rts,
   output logic             txCrcEnable,
   output logic      [7:0]  syncPattern
);
   logic [7:0] intVector;
   logic [7:0] rxPar;
   logic [7:0] lineMode;
   logic [7:0] txPar;
   logic [7:0] syncAddr;
   logic [3:0] pointer;

   wire        wrAccess;
   wire        rdAccess;
   wire        hitPointer;
   wire        hitData;
   wire [3:0]  directIdx;
   wire        directHit;
   wire [3:0]  target;
   wire        tgtValid;
   wire [7:0]  wbyte;
   wire        mapped;

   reg_write_if rw ();

   function automatic logic [3:0] addr_index(input logic [11:0] a);
      unique case (a)
         OFF_VECTOR:   addr_index = IDX_VECTOR;
         OFF_RXPAR:    addr_index = IDX_RXPAR;
         OFF_LINEMODE: addr_index = IDX_LINEMODE;
         OFF_TXPAR:    addr_index = IDX_TXPAR;
         OFF_SYNCADDR: addr_index = IDX_SYNCADDR;
         default:      addr_index = 4'hF;
      endcase
   endfunction : addr_index

   assign wrAccess   = psel && penable && pwrite;
   assign rdAccess   = psel && penable && !pwrite;
   assign wbyte      = pwdata[7:0];
   assign hitPointer = (paddr == OFF_POINTER);
   assign hitData    = (paddr == OFF_DATA);
   assign directIdx  = addr_index(paddr);
   assign directHit  = (directIdx != 4'hF);
   assign mapped     = hitPointer || hitData || directHit;
   assign target     = hitData ? pointer : directIdx;
   assign tgtValid   = hitData || directHit;
   assign pready     = 1'b1;
   // write-only bank: reads return zero, unmapped is an error
   assign pslverr    = psel && penable && !mapped;

   always_ff @(posedge clk) begin
      prdata <= ERR_DATA;
   end

   // pointer from command write, point high adds eight
   always_ff @(posedge clk) begin
      if (!nrst) begin
         pointer   <= 4'h0;
      end else if (wrAccess && hitPointer) begin
         pointer   <= {wbyte[POS_CMD +: 3] == CMD_POINT_HIGH, wbyte[2:0]};
      end else if (wrAccess && hitData) begin
         pointer <= 4'h0;
      end
   end

   always_ff @(posedge clk) begin
      if (wrAccess && tgtValid && target == IDX_VECTOR)
         intVector <= wbyte;
   end

   // sync and address register, no reset
   always_ff @(posedge clk) begin
      if (wrAccess && tgtValid && target == IDX_SYNCADDR)
         syncAddr <= wbyte;
   end

   always_ff @(posedge clk) begin
      if (!nrst)
         rxPar <= rxPar & RST_CLR_RXPAR;
      else if (wrAccess && tgtValid && target == IDX_RXPAR)
         rxPar <= wbyte;
   end

   // line mode: stop mode bit set, parity off at reset
   always_ff @(posedge clk) begin
      if (!nrst)
         lineMode <= (lineMode & RST_CLR_LINE) | RST_SET_LINE;
      else if (wrAccess && tgtValid && target == IDX_LINEMODE)
         lineMode <= wbyte;
   end

   // reset clears dtr, break, enable, crc select, rts
   always_ff @(posedge clk) begin
      if (!nrst)
         txPar <= txPar & RST_CLR_TXPAR;
      else if (wrAccess && tgtValid && target == IDX_TXPAR)
         txPar <= wbyte;
   end

   assign vectorOut       = intVector;
   assign rxEnable        = rxPar[POS_RX_ENABLE];
   assign syncLoadInhibit = rxPar[POS_SYNC_INHIB];
   assign addressSearch   = rxPar[POS_ADDR_SRCH];
   assign rxCrcEnable     = rxPar[POS_RX_CRC];
   assign syncSearchState = rxPar[POS_SYNC_SEARCH_STATE];
   assign autoEnable      = rxPar[POS_AUTO_EN];
   assign rxCharLen       = rxPar[POS_CHAR_LEN +: 2];
   assign clockDivide     = lineMode[POS_CLKDIV +: 2];
   assign syncMode        = lineMode[POS_SYNCMODE +: 2];
   assign stopMode        = lineMode[POS_STOP +: 2];
   assign parityEven      = lineMode[POS_PAR_EVEN];
   assign parityEnable    = lineMode[POS_PAR_EN];
   assign dtr             = txPar[POS_DTR];
   assign txCharLen       = txPar[POS_TX_LEN +: 2];
   assign sendBreak       = txPar[POS_BREAK];
   assign txEnable        = txPar[POS_TX_EN];
   assign crc16Select     = txPar[POS_CRC16];
   assign rts             = txPar[POS_RTS];
   assign txCrcEnable     = txPar[POS_TX_CRC_EN];
   // twelve-bit sync forces low nibble to ones
   assign syncPattern = (syncMode == SYNC16 && rxCharLen == BITS5) ?
                        (syncAddr | LOW_NIBBLE) : syncAddr;

   assign rw.station    = syncAddr;
   assign rw.rangeMode  = rangeMode;
   assign rw.frameAddr  = frameAddr;
   assign rw.frameValid = frameValid;

   station_matcher u_match (
      .m (rw.matcher)
   );

   // accept only matching frames in address search with flag sync mode
   assign frameAccept = frameValid &&
      (!(addressSearch && syncMode == FLAGS) || rw.match);

   rx_enable_reset_a: assert property (@(posedge clk)
      !nrst |=> !rxEnable) else $error("rx enable not cleared");
   tx_reset_a: assert property (@(posedge clk)
      !nrst |=> !dtr && !sendBreak && !txEnable && !crc16Select && !rts)
      else $error("tx fields not cleared");
   vector_write_a: assert property (@(posedge clk)
      disable iff (!nrst)
      wrAccess && paddr == OFF_VECTOR |=> vectorOut == $past(wbyte))
      else $error("vector not stored");
   search_reject_a: assert property (@(posedge clk)
      addressSearch && syncMode == FLAGS && !rw.match |-> !frameAccept)
      else $error("mismatched frame accepted");
   line_write_a: assert property (@(posedge clk) disable iff (!nrst)
      wrAccess && paddr == OFF_LINEMODE |=>
      clockDivide == $past(wbyte[7:6]) && parityEnable == $past(wbyte[0]))
      else $error("line mode not stored");
   range_match_a: assert property (@(posedge clk)
      frameValid && rangeMode && frameAddr[7:4] == syncAddr[7:4]
      |-> rw.match) else $error("range compare wrong");
   sequence pointSeq;
      wrAccess && hitPointer && wbyte[5:3] == CMD_POINT_HIGH;
   endsequence
   point_high_a: assert property (@(posedge clk) disable iff (!nrst)
      pointSeq |=> pointer[3])
      else $error("point high ignored");
   pointer_clear_a: assert property (@(posedge clk)
      disable iff (!nrst) wrAccess && hitData |=> pointer == 4'h0)
      else $error("pointer not cleared");
   read_zero_a: assert property (@(posedge clk) disable iff (!nrst)
      rdAccess |-> prdata == ERR_DATA) else $error("read data not zero");
   bisync_ones_a: assert property (@(posedge clk)
      syncMode == SYNC16 && rxCharLen == BITS5 |->
      syncPattern[3:0] == LOW_NIBBLE[3:0]) else $error("sync ones missing");
   tx_write_a: assert property (@(posedge clk) disable iff (!nrst)
      wrAccess && paddr == OFF_TXPAR |=>
      dtr == $past(wbyte[POS_DTR]) && rts == $past(wbyte[POS_RTS]))
      else $error("tx parameters not stored");
   stray_write_a: assert property (@(posedge clk)
      disable iff (!nrst) wrAccess && !mapped |=>
      $stable(intVector) && $stable(rxPar) && $stable(lineMode) &&
      $stable(txPar) && $stable(syncAddr))
      else $error("unmapped write changed a register");
endmodule : serial_channel_mode_registers

// [src/mode_regs_pkg.sv]
// constants and types for the serial channel mode register bank
package mode_regs_pkg;
   localparam logic [11:0] OFF_POINTER    = 12'h000;
   localparam logic [11:0] OFF_DATA       = 12'h004;
   localparam logic [11:0] OFF_VECTOR     = 12'h008;
   localparam logic [11:0] OFF_RXPAR      = 12'h00C;
   localparam logic [11:0] OFF_LINEMODE   = 12'h010;
   localparam logic [11:0] OFF_TXPAR      = 12'h014;
   localparam logic [11:0] OFF_SYNCADDR   = 12'h018;
   localparam logic [3:0]  IDX_VECTOR     = 4'h2;
   localparam logic [3:0]  IDX_RXPAR      = 4'h3;
   localparam logic [3:0]  IDX_LINEMODE   = 4'h4;
   localparam logic [3:0]  IDX_TXPAR      = 4'h5;
   localparam logic [3:0]  IDX_SYNCADDR   = 4'h6;
   localparam logic [2:0]  CMD_POINT_HIGH = 3'h1;
   localparam int          POS_CMD        = 3;
   localparam int          POS_RX_ENABLE  = 0;
   localparam int          POS_SYNC_INHIB = 1;
   localparam int          POS_ADDR_SRCH  = 2;
   localparam int          POS_RX_CRC     = 3;
   localparam int          POS_SYNC_SEARCH_STATE       = 4;
   localparam int          POS_AUTO_EN    = 5;
   localparam int          POS_CHAR_LEN   = 6;
   localparam int          POS_PAR_EN     = 0;
   localparam int          POS_PAR_EVEN   = 1;
   localparam int          POS_STOP       = 2;
   localparam int          POS_SYNCMODE   = 4;
   localparam int          POS_CLKDIV     = 6;
   localparam int          POS_TX_CRC_EN  = 0;
   localparam int          POS_RTS        = 1;
   localparam int          POS_CRC16      = 2;
   localparam int          POS_TX_EN      = 3;
   localparam int          POS_BREAK      = 4;
   localparam int          POS_TX_LEN     = 5;
   localparam int          POS_DTR        = 7;
   localparam logic [7:0]  RST_CLR_RXPAR  = 8'hFE;
   localparam logic [7:0]  RST_CLR_TXPAR  = 8'h61;
   localparam logic [7:0]  RST_SET_LINE   = 8'h04;
   localparam logic [7:0]  RST_CLR_LINE   = 8'hFE;
   localparam logic [7:0]  RST_ANY        = 8'h00;
   localparam logic [7:0]  RANGE_MASK     = 8'hF0;
   localparam logic [7:0]  LOW_NIBBLE     = 8'h0F;
   localparam logic [31:0] ERR_DATA       = 32'h0000_0000;
   typedef enum logic [1:0] {
      SYNC8 = 2'b00, SYNC16 = 2'b01, FLAGS = 2'b10, EXTSYNC = 2'b11
   } sync_mode_t;
   typedef enum logic [1:0] {
      BITS5 = 2'b00, BITS7 = 2'b01, BITS6 = 2'b10, BITS8 = 2'b11
   } char_len_t;
   typedef enum logic [1:0] {
      DIV1 = 2'b00, DIV16 = 2'b01, DIV32 = 2'b10, DIV64 = 2'b11
   } clk_div_t;
   typedef enum logic [1:0] {
      SYNCHRONOUS = 2'b00, STOP1 = 2'b01, STOP15 = 2'b10, STOP2 = 2'b11
   } stop_mode_t;
endpackage : mode_regs_pkg

// [src/reg_write_if.sv]
// frame address compare bundle between register bank and matcher
`timescale 1ns/1ps
interface reg_write_if;
   logic [7:0] station;
   logic       rangeMode;
   logic [7:0] frameAddr;
   logic       frameValid;
   logic       match;
   modport owner (output station, rangeMode, frameAddr, frameValid,
                  input match);
   modport matcher (input station, rangeMode, frameAddr, frameValid,
                    output match);
endinterface : reg_write_if

// [src/station_matcher.sv]
// station address compare for frame address search
`timescale 1ns/1ps
module station_matcher
   import mode_regs_pkg::*;
(
   reg_write_if.matcher m
);
   wire [7:0] cmpMask;
   assign cmpMask = m.rangeMode ? RANGE_MASK : 8'hFF;
   assign m.match = m.frameValid &&
                    ((m.frameAddr & cmpMask) == (m.station & cmpMask));
endmodule : station_matcher

// [bench/serial_channel_mode_registers_bench.sv]
// apb bench for the serial channel mode register bank
`timescale 1ns/1ps
module serial_channel_mode_registers_bench
   import mode_regs_pkg::*;
   ;
   logic        clk, nrst, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [7:0]  frameAddr, vectorOut, syncPattern;
   logic        frameValid, rangeMode, frameAccept, er;
   logic        rxEnable, syncLoadInhibit, addressSearch, rxCrcEnable;
   logic        syncSearchState, autoEnable, parityEven, parityEnable;
   logic        dtr, sendBreak, txEnable, crc16Select, rts, txCrcEnable;
   logic [1:0]  rxCharLen, clockDivide, syncMode, stopMode, txCharLen;
   int          err_count, checked;
   wire  [7:0]  rxF = {rxCharLen, autoEnable, syncSearchState, rxCrcEnable,
                       addressSearch, syncLoadInhibit, rxEnable};
   wire  [7:0]  lineF = {clockDivide, syncMode, stopMode, parityEven,
                         parityEnable};
   wire  [7:0]  txF = {dtr, txCharLen, sendBreak, txEnable, crc16Select,
                       rts, txCrcEnable};

   serial_channel_mode_registers u_serial_channel_mode_registers (
      .clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .frameAddr, .frameValid, .rangeMode, .frameAccept,
      .vectorOut, .rxEnable, .syncLoadInhibit, .addressSearch, .rxCrcEnable,
      .syncSearchState, .autoEnable, .rxCharLen, .clockDivide, .syncMode,
      .stopMode, .parityEven, .parityEnable, .dtr, .txCharLen, .sendBreak,
      .txEnable, .crc16Select, .rts, .txCrcEnable, .syncPattern);

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   task automatic end_sim();
      $display("checks %0d errors %0d", checked, err_count);
      if (err_count == 0 && checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : end_sim

   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      checked++;
      if (g !== e) begin
         err_count++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   // bounded wait on pready; a hang ends the run
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin
         err_count++;
         $display("BAD pready expected 1 seen %b", pready);
         end_sim();
      end
      @(negedge clk);
   endtask : apb

   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      apb(1'b1, a, {24'h000000, d});
      chk("pslverr", 32'h0, {31'h0, er});
   endtask : wr

   task automatic rst();
      @(posedge clk);
      nrst <= 1'b0;
      repeat (20) @(posedge clk);
      nrst <= 1'b1;
      @(negedge clk);
      chk("rxEnable", 32'h0, {31'h0, rxEnable});
      chk("lineRst", 32'h04, {24'h0, lineF & 8'h05});
      chk("txRst", 32'h00, {24'h0, txF & 8'h9E});
   endtask : rst

   task automatic frm(input logic v, input logic [7:0] a, input logic r,
                      input logic e);
      @(posedge clk);
      frameValid <= v;
      frameAddr <= a;
      rangeMode <= r;
      @(negedge clk);
      chk("frameAccept", {31'h0, e}, {31'h0, frameAccept});
   endtask : frm

   initial begin
      logic [7:0] v;
      nrst = 1'b0;
      {psel, penable, pwrite, frameValid, rangeMode} = 5'h00;
      {paddr, pwdata, frameAddr} = 52'h0;
      err_count = 0;
      checked = 0;
      rst();
      // patterns 00 55 AA FF reach every two-bit code of every field
      for (int i = 0; i < 4; i++) begin
         v = 8'h55 * i[7:0];
         wr(OFF_VECTOR, v);
         wr(OFF_RXPAR, v);
         wr(OFF_LINEMODE, v);
         wr(OFF_TXPAR, v);
         chk("vector", {24'h0, v}, {24'h0, vectorOut});
         chk("rx", {24'h0, v}, {24'h0, rxF});
         chk("line", {24'h0, v}, {24'h0, lineF});
         chk("tx", {24'h0, v}, {24'h0, txF});
      end
      wr(OFF_POINTER, {5'h00, IDX_VECTOR[2:0]});
      wr(OFF_DATA, 8'h3C);
      chk("ptrVector", 32'h3C, {24'h0, vectorOut});
      wr(OFF_DATA, 8'h77);
      chk("ptrBack", 32'h3C, {24'h0, vectorOut});
      wr(OFF_POINTER, {2'b00, CMD_POINT_HIGH, IDX_RXPAR[2:0]});
      wr(OFF_DATA, 8'h00);
      chk("ptrHigh", 32'hFF, {24'h0, rxF});
      wr(OFF_POINTER, {5'h00, IDX_RXPAR[2:0]});
      wr(OFF_DATA, 8'h00);
      chk("ptrRx", 32'h00, {24'h0, rxF});
      wr(OFF_LINEMODE, 8'h10);
      wr(OFF_SYNCADDR, 8'hA5);
      chk("bisync12", 32'hAF, {24'h0, syncPattern});
      wr(OFF_LINEMODE, 8'h00);
      chk("monosync", 32'hA5, {24'h0, syncPattern});
      // full-length bisync keeps the low nibble as written
      wr(OFF_RXPAR, 8'hC0);
      wr(OFF_LINEMODE, 8'h10);
      chk("bisync16", 32'hA5, {24'h0, syncPattern});
      wr(OFF_LINEMODE, 8'h20);
      wr(OFF_SYNCADDR, 8'h5C);
      wr(OFF_RXPAR, 8'h04);
      chk("station", 32'h5C, {24'h0, syncPattern});
      frm(1'b1, 8'h5C, 1'b0, 1'b1);
      frm(1'b1, 8'h5D, 1'b0, 1'b0);
      frm(1'b1, 8'h53, 1'b1, 1'b1);
      frm(1'b1, 8'h6C, 1'b1, 1'b0);
      frm(1'b0, 8'h5C, 1'b0, 1'b0);
      wr(OFF_RXPAR, 8'h00);
      frm(1'b1, 8'h00, 1'b0, 1'b1);
      // unmapped write refused, vector register untouched
      apb(1'b1, 12'h01C, 32'h000000FF);
      chk("unmapped", 32'h1, {31'h0, er});
      chk("vectorKeep", 32'h3C, {24'h0, vectorOut});
      apb(1'b0, OFF_RXPAR, 32'h0);
      chk("readData", 32'h0, rd);
      chk("readErr", 32'h0, {31'h0, er});
      wr(OFF_TXPAR, 8'hFF);
      wr(OFF_RXPAR, 8'hFF);
      rst();
      end_sim();
   end
endmodule : serial_channel_mode_registers_bench
